// file: logic/alu_status_flag_logic.v
/*
  status-flag generation for an 8-bit core: main and alternate flag
  registers, per-operation flag update, branch condition output, and an
  ahb-lite slave for software access to both flag registers.
  assumes the arithmetic unit supplies operands, result and carries on
  the same clock, with opStrobe high for one cycle per completed op.
*/
// Operation
// - sign at bit 7, zero bit 6, parity/overflow bit 2, carry bit 0.
// - main and alternate flag registers; bits 3 and 5 hold nothing.
// - branches test only carry, parity/overflow, zero and sign.
// - carry set on add carry out or subtract borrow, else cleared.
// - decimal adjust sets carry when correction conditions are met.
// - left rotates and left arithmetic shift put old bit 7 in carry.
// - right rotates and right shifts put old bit 0 in carry.
// - rotate through carry uses carry as ninth link bit.
// - and, or, exclusive-or always clear carry.
// - set-carry forces carry to 1; complement-carry inverts it.
// - add clears add/subtract flag, subtract sets it.
// - arithmetic overflow is carry into sign xor carry out of sign.
// - logic and rotate ops put even parity of result in p/v.
// - block search/move clear p/v when byte count reaches 0.
// - loading accumulator from vector/refresh copies interrupt latch.
// - port input sets parity, zero and sign from the byte.
// - half carry from bit 3 to 4 on add, borrow from bit 4 on sub.
// - arithmetic and logic ops set zero when result byte is zero.
// - compare sets zero when accumulator equals memory byte.
// - bit test puts inverted selected bit into zero.
// - block input/output sets zero when decremented b is 0.
// - sign flag holds bit 7 of the result.
`timescale 1ns/1ps
`default_nettype none
`include "flag_logic_defines.vh"

module alu_status_flag_logic (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // operation from the sequencer and arithmetic unit
  input wire opStrobe,
  input wire [4:0] opClass,
  input wire [7:0] operandA,
  input wire [7:0] operandB,
  input wire [7:0] result,
  input wire carryOut,
  input wire carryIntoSign,
  input wire halfCarry,
  input wire decimalCarry,
  input wire [2:0] bitSelect,
  input wire byteCountZero,
  input wire countBZero,
  input wire second_interrupt_enable_latch,
  // branch condition
  input wire [2:0] condSel,
  output wire condTrue,
  // flag outputs
  output wire [7:0] statusFlags,
  output wire [7:0] alternateFlags,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function evenParity;
    input [7:0] v;
    begin
      evenParity = ~^v;
    end
  endfunction

  function [7:0] packFlags;
    input s;
    input z;
    input h;
    input pv;
    input n;
    input c;
    begin
      packFlags = 8'h00;
      packFlags[`FLAG_SIGN_BIT] = s;
      packFlags[`FLAG_ZERO_BIT] = z;
      packFlags[`FLAG_HALF_BIT] = h;
      packFlags[`FLAG_PV_BIT] = pv;
      packFlags[`FLAG_SUB_BIT] = n;
      packFlags[`FLAG_CARRY_BIT] = c;
    end
  endfunction

  reg [7:0] flags_reg;
  reg [7:0] altFlags_reg;
  reg [7:0] flags_next;
  reg [7:0] altFlags_next;

  wire sF = flags_reg[`FLAG_SIGN_BIT];
  wire zF = flags_reg[`FLAG_ZERO_BIT];
  wire hF = flags_reg[`FLAG_HALF_BIT];
  wire pF = flags_reg[`FLAG_PV_BIT];
  wire nF = flags_reg[`FLAG_SUB_BIT];
  wire cF = flags_reg[`FLAG_CARRY_BIT];
  wire resZero = (result == 8'h00);
  wire resSign = result[7];
  wire overflow = carryIntoSign ^ carryOut;

  // ----------------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------------
  reg wrPend_reg;
  reg [7:0] wrAddr_reg;
  wire addrPhase = hsel & hready & htrans[1];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else begin
      wrPend_reg <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase & ~hwrite) begin
      case (haddr)
        `ADDR_STATUS_FLAGS: hrdata <= {24'h000000, flags_reg};
        `ADDR_ALT_STATUS_FLAGS: hrdata <= {24'h000000, altFlags_reg};
        `ADDR_CONDITION: hrdata <= {31'h00000000, condTrue};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // flag update per operation
  // ----------------------------------------------------------------------
  always @* begin
    flags_next = flags_reg;
    altFlags_next = altFlags_reg;
    if (wrPend_reg && wrAddr_reg == `ADDR_STATUS_FLAGS) begin
      flags_next = hwdata[7:0] & `FLAG_USED_MASK;
    end
    if (wrPend_reg && wrAddr_reg == `ADDR_ALT_STATUS_FLAGS) begin
      altFlags_next = hwdata[7:0] & `FLAG_USED_MASK;
    end
    if (opStrobe) begin
      case (opClass)
        `OP_ADD: begin
          flags_next = packFlags(
            resSign,
            resZero,
            halfCarry,
            overflow,
            1'b0,
            carryOut
          );
        end
        `OP_SUB: begin
          // carryOut already signals a borrow here
          flags_next = packFlags(
            resSign,
            resZero,
            halfCarry,
            overflow,
            1'b1,
            carryOut
          );
        end
        `OP_COMPARE: begin
          flags_next = packFlags(
            resSign,
            operandA == operandB,
            halfCarry,
            overflow,
            1'b1,
            carryOut
          );
        end
        `OP_LOGIC_AND: begin
          flags_next = packFlags(
            resSign,
            resZero,
            1'b1,
            evenParity(result),
            1'b0,
            1'b0
          );
        end
        `OP_LOGIC_OR: begin
          flags_next = packFlags(
            resSign,
            resZero,
            1'b0,
            evenParity(result),
            1'b0,
            1'b0
          );
        end
        `OP_DECIMAL_ADJUST: begin
          flags_next = packFlags(
            resSign,
            resZero,
            halfCarry,
            evenParity(result),
            nF,
            cF | decimalCarry
          );
        end
        `OP_ROT_LEFT_CIRC, `OP_SHIFT_LEFT_ARITH: begin
          flags_next = packFlags(
            resSign,
            resZero,
            1'b0,
            evenParity(result),
            1'b0,
            operandA[7]
          );
        end
        `OP_ROT_RIGHT_CIRC, `OP_SHIFT_RIGHT_ARITH,
        `OP_SHIFT_RIGHT_LOGICAL: begin
          flags_next = packFlags(
            resSign,
            resZero,
            1'b0,
            evenParity(result),
            1'b0,
            operandA[0]
          );
        end
        `OP_ROT_LEFT_LINK: begin
          // old carry fed into bit 0 by the unit; old bit 7 leaves
          flags_next = packFlags(
            resSign,
            resZero,
            1'b0,
            evenParity(result),
            1'b0,
            operandA[7]
          );
        end
        `OP_ROT_RIGHT_LINK: begin
          flags_next = packFlags(
            resSign,
            resZero,
            1'b0,
            evenParity(result),
            1'b0,
            operandA[0]
          );
        end
        `OP_SET_CARRY: begin
          flags_next = packFlags(sF, zF, 1'b0, pF, 1'b0, 1'b1);
        end
        `OP_COMPLEMENT_CARRY: begin
          flags_next = packFlags(sF, zF, cF, pF, 1'b0, ~cF);
        end
        `OP_COMPARE_BLOCK: begin
          flags_next = packFlags(
            resSign,
            operandA == operandB,
            halfCarry,
            ~byteCountZero,
            1'b1,
            cF
          );
        end
        `OP_MOVE_BLOCK: begin
          flags_next = packFlags(sF, zF, 1'b0, ~byteCountZero, 1'b0, cF);
        end
        `OP_LOAD_IE_STATE: begin
          flags_next = packFlags(
            resSign,
            resZero,
            1'b0,
            second_interrupt_enable_latch,
            1'b0,
            cF
          );
        end
        `OP_PORT_INPUT: begin
          flags_next = packFlags(
            resSign,
            resZero,
            1'b0,
            evenParity(result),
            1'b0,
            cF
          );
        end
        `OP_BIT_TEST: begin
          flags_next = packFlags(
            sF,
            ~operandA[bitSelect],
            1'b1,
            pF,
            1'b0,
            cF
          );
        end
        `OP_BLOCK_IO: begin
          flags_next = packFlags(sF, countBZero, hF, pF, 1'b1, cF);
        end
        `OP_EXCHANGE: begin
          flags_next = altFlags_reg;
          altFlags_next = flags_reg;
        end
        default: begin
          flags_next = flags_next;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= `FLAG_RESET_VALUE;
      altFlags_reg <= `FLAG_RESET_VALUE;
    end else begin
      flags_reg <= flags_next;
      altFlags_reg <= altFlags_next;
    end
  end

  // ----------------------------------------------------------------------
  // branch condition: half carry and add/subtract are not selectable
  // ----------------------------------------------------------------------
  reg condVal;
  always @* begin
    case (condSel)
      `COND_NOT_ZERO: condVal = ~zF;
      `COND_ZERO: condVal = zF;
      `COND_NO_CARRY: condVal = ~cF;
      `COND_CARRY: condVal = cF;
      `COND_PARITY_ODD: condVal = ~pF;
      `COND_PARITY_EVEN: condVal = pF;
      `COND_POSITIVE: condVal = ~sF;
      default: condVal = sF;
    endcase
  end

  assign condTrue = condVal;
  assign statusFlags = flags_reg;
  assign alternateFlags = altFlags_reg;

endmodule
`default_nettype wire

// file: inc/flag_logic_defines.vh
/*
  flag register layout, operation class codes, branch condition codes
  and register offsets for the status-flag block.
  assumes inclusion by bare name from design and bench files.
*/
`ifndef FLAG_LOGIC_DEFINES_VH
`define FLAG_LOGIC_DEFINES_VH

// ----------------------------------------------------------------------
// flag bit positions
// ----------------------------------------------------------------------
`define FLAG_SIGN_BIT 7
`define FLAG_ZERO_BIT 6
`define FLAG_HALF_BIT 4
`define FLAG_PV_BIT 2
`define FLAG_SUB_BIT 1
`define FLAG_CARRY_BIT 0
`define FLAG_USED_MASK 8'hd7
`define FLAG_RESET_VALUE 8'h00

// ----------------------------------------------------------------------
// operation classes (opClass input, 5 bits)
// ----------------------------------------------------------------------
`define OP_NONE 5'h00
`define OP_ADD 5'h01
`define OP_SUB 5'h02
`define OP_LOGIC_AND 5'h03
`define OP_LOGIC_OR 5'h04
`define OP_DECIMAL_ADJUST 5'h05
`define OP_ROT_LEFT_CIRC 5'h06
`define OP_SHIFT_LEFT_ARITH 5'h07
`define OP_ROT_RIGHT_CIRC 5'h08
`define OP_SHIFT_RIGHT_ARITH 5'h09
`define OP_SHIFT_RIGHT_LOGICAL 5'h0a
`define OP_ROT_LEFT_LINK 5'h0b
`define OP_ROT_RIGHT_LINK 5'h0c
`define OP_SET_CARRY 5'h0d
`define OP_COMPLEMENT_CARRY 5'h0e
`define OP_COMPARE_BLOCK 5'h0f
`define OP_MOVE_BLOCK 5'h10
`define OP_LOAD_IE_STATE 5'h11
`define OP_PORT_INPUT 5'h12
`define OP_BIT_TEST 5'h13
`define OP_BLOCK_IO 5'h14
`define OP_EXCHANGE 5'h15
`define OP_COMPARE 5'h16

// ----------------------------------------------------------------------
// branch condition codes (condSel input, 3 bits)
// ----------------------------------------------------------------------
`define COND_NOT_ZERO 3'h0
`define COND_ZERO 3'h1
`define COND_NO_CARRY 3'h2
`define COND_CARRY 3'h3
`define COND_PARITY_ODD 3'h4
`define COND_PARITY_EVEN 3'h5
`define COND_POSITIVE 3'h6
`define COND_NEGATIVE 3'h7

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_STATUS_FLAGS 8'h00
`define ADDR_ALT_STATUS_FLAGS 8'h04
`define ADDR_CONDITION 8'h08

`endif

// file: verification/flag_checker_sva.sv
/* flag checker: timing relations at the status-flag block's ports.
   assumes a bind onto alu_status_flag_logic, one core_clk domain. */
`timescale 1ns/1ps
`default_nettype none
`include "flag_logic_defines.vh"
module flag_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // operation side
  input wire logic opStrobe,
  input wire logic [4:0] opClass,
  input wire logic [7:0] operandA,
  input wire logic [7:0] result,
  input wire logic carryOut,
  input wire logic carryIntoSign,
  input wire logic halfCarry,
  input wire logic [2:0] bitSelect,
  input wire logic byteCountZero,
  // flags and condition
  input wire logic [2:0] condSel,
  input wire logic condTrue,
  input wire logic [7:0] statusFlags,
  input wire logic [7:0] alternateFlags,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] htrans,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic [3:0] pick;
  assign pick = {statusFlags[7], statusFlags[2], statusFlags[0],
    statusFlags[6]};
  // ----------------------------------------------------------------
  // operation sequences
  // ----------------------------------------------------------------
  sequence arith;
    opStrobe && opClass inside {`OP_ADD, `OP_SUB};
  endsequence
  sequence logicOp;
    opStrobe && opClass inside {`OP_LOGIC_AND, `OP_LOGIC_OR};
  endsequence
  sequence leftOut;
    opStrobe && opClass inside {`OP_ROT_LEFT_CIRC, `OP_SHIFT_LEFT_ARITH,
      `OP_ROT_LEFT_LINK};
  endsequence
  sequence rightOut;
    opStrobe && opClass inside {`OP_ROT_RIGHT_CIRC, `OP_SHIFT_RIGHT_ARITH,
      `OP_SHIFT_RIGHT_LOGICAL, `OP_ROT_RIGHT_LINK};
  endsequence
  unused_bits_a: assert property (
    (statusFlags & 8'h28) == 8'h00 && (alternateFlags & 8'h28) == 8'h00)
    else $error("undefined flag bit set");
  arith_flags_a: assert property (arith |=>
    statusFlags[0] == $past(carryOut) && statusFlags[4] == $past(halfCarry)
    && statusFlags[2] == $past(carryIntoSign ^ carryOut)
    && statusFlags[1] == ($past(opClass) == `OP_SUB))
    else $error("arithmetic flags wrong");
  zero_sign_a: assert property ((arith or logicOp) |=>
    statusFlags[6] == ($past(result) == 8'h00)
    && statusFlags[7] == $past(result[7])) else $error("zero or sign wrong");
  logic_flags_a: assert property (logicOp |=>
    !statusFlags[0] && statusFlags[2] == ~^$past(result))
    else $error("logic carry or parity wrong");
  carry_flip_a: assert property (
    opStrobe && opClass == `OP_COMPLEMENT_CARRY |=>
    statusFlags[0] != $past(statusFlags[0])) else $error("carry not flipped");
  left_out_a: assert property (leftOut |=>
    statusFlags[0] == $past(operandA[7])) else $error("left carry wrong");
  right_out_a: assert property (rightOut |=>
    statusFlags[0] == $past(operandA[0])) else $error("right carry wrong");
  block_pv_a: assert property (
    opStrobe && opClass inside {`OP_COMPARE_BLOCK, `OP_MOVE_BLOCK} |=>
    statusFlags[2] == !$past(byteCountZero)) else $error("block pv wrong");
  bit_test_a: assert property (
    opStrobe && opClass == `OP_BIT_TEST |=>
    statusFlags[6] == !$past(operandA[bitSelect])) else $error("bit test");
  cond_pick_a: assert property (
    condTrue == (pick[condSel[2:1]] ~^ condSel[0])) else $error("cond bad");
  bus_okay_a: assert property (hsel && htrans[1] |=> hreadyout && !hresp)
    else $error("bus not ready or not okay");
  read_word_a: assert property (
    hsel && htrans[1] && !hwrite && haddr == `ADDR_STATUS_FLAGS |=>
    hrdata == {24'h000000, $past(statusFlags)})
    else $error("main flags read wrong");
endmodule
bind alu_status_flag_logic flag_checker chk (.core_clk(core_clk),
  .arst_n(arst_n), .opStrobe(opStrobe), .opClass(opClass),
  .operandA(operandA), .result(result), .carryOut(carryOut),
  .carryIntoSign(carryIntoSign), .halfCarry(halfCarry),
  .bitSelect(bitSelect), .byteCountZero(byteCountZero), .condSel(condSel),
  .condTrue(condTrue), .statusFlags(statusFlags),
  .alternateFlags(alternateFlags), .hsel(hsel), .haddr(haddr),
  .hwrite(hwrite), .hrdata(hrdata), .htrans(htrans),
  .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// file: verification/testbench.sv
/* testbench for the status-flag block: op table, bus access, conditions.
   assumes flag_logic_defines.vh and the bound flag_checker. */
`timescale 1ns/1ps
`default_nettype none
`include "flag_logic_defines.vh"
module testbench;
  typedef struct packed {
    logic [4:0] op; logic [7:0] a; logic [7:0] r; logic [6:0] c;
    logic [2:0] b; logic [7:0] m; logic [7:0] e;
  } row_t;
  logic core_clk, arst_n, opStrobe, hsel, hwrite, hreadyout, hresp, condTrue;
  logic [4:0] opClass;
  logic [7:0] operandA, operandB, result, haddr, statusFlags, alternateFlags;
  logic [6:0] ctl;
  logic [2:0] bitSelect, condSel, hsize;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  int n_errors, n_compared;
  // c: carryOut carryIntoSign halfCarry decimalCarry byteCount bZero ie
  row_t rows [0:25] = '{
    {`OP_ADD,16'h0000,7'h70,3'h0,16'hd751},
    {`OP_ADD,16'h78e1,7'h30,3'h0,16'hd794},
    {`OP_SUB,16'h7fbf,7'h40,3'h0,16'hd787},
    {`OP_SUB,16'h100f,7'h10,3'h0,16'hd712},
    {`OP_LOGIC_AND,16'h0003,7'h40,3'h0,16'hd514},
    {`OP_LOGIC_OR,16'h0080,7'h40,3'h0,16'hd580},
    {`OP_SET_CARRY,16'h0000,7'h00,3'h0,16'h1101},
    {`OP_COMPLEMENT_CARRY,16'h0000,7'h00,3'h0,16'h1110},
    {`OP_ROT_LEFT_CIRC,16'h8001,7'h00,3'h0,16'h0501},
    {`OP_SHIFT_LEFT_ARITH,16'h7ffe,7'h40,3'h0,16'h0500},
    {`OP_DECIMAL_ADJUST,16'h0000,7'h08,3'h0,16'h0101},
    {`OP_ROT_RIGHT_CIRC,16'h0180,7'h00,3'h0,16'h0501},
    {`OP_SHIFT_RIGHT_ARITH,16'h80c0,7'h40,3'h0,16'h0504},
    {`OP_SHIFT_RIGHT_LOGICAL,16'h0301,7'h00,3'h0,16'h0501},
    {`OP_ROT_LEFT_LINK,16'h0001,7'h00,3'h0,16'h0500},
    {`OP_ROT_RIGHT_LINK,16'h0100,7'h00,3'h0,16'h0505},
    {`OP_COMPARE_BLOCK,16'h0000,7'h04,3'h0,16'h0400},
    {`OP_MOVE_BLOCK,16'h0000,7'h00,3'h0,16'h0404},
    {`OP_LOAD_IE_STATE,16'h0000,7'h00,3'h0,16'h0400},
    {`OP_LOAD_IE_STATE,16'h0000,7'h01,3'h0,16'h0404},
    {`OP_BIT_TEST,16'h2000,7'h00,3'h4,16'h4040},
    {`OP_BIT_TEST,16'h2000,7'h00,3'h5,16'h4000},
    {`OP_BLOCK_IO,16'h0000,7'h02,3'h0,16'h4040},
    {`OP_PORT_INPUT,16'h8383,7'h00,3'h0,16'hc480},
    {`OP_COMPARE,16'h4200,7'h00,3'h0,16'h4040},
    {`OP_COMPARE,16'h4201,7'h00,3'h0,16'hc000}};
  alu_status_flag_logic dut (.core_clk(core_clk), .arst_n(arst_n),
    .opStrobe(opStrobe), .opClass(opClass), .operandA(operandA),
    .operandB(operandB), .result(result), .carryOut(ctl[6]),
    .carryIntoSign(ctl[5]), .halfCarry(ctl[4]), .decimalCarry(ctl[3]),
    .bitSelect(bitSelect), .byteCountZero(ctl[2]), .countBZero(ctl[1]),
    .second_interrupt_enable_latch(ctl[0]), .condSel(condSel),
    .condTrue(condTrue), .statusFlags(statusFlags),
    .alternateFlags(alternateFlags), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input int wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask
  task automatic runOp(input row_t x);
    @(posedge core_clk);
    opStrobe <= 1'b1;
    opClass <= x.op;
    operandA <= x.a;
    operandB <= x.a - x.r;
    result <= x.r;
    ctl <= x.c;
    bitSelect <= x.b;
    @(posedge core_clk);
    opStrobe <= 1'b0;
    #1;
  endtask
  task automatic condSweep(input logic [7:0] exp);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      condSel <= i[2:0];
      #1;
      check("condTrue", condTrue, exp[i]);
    end
  endtask
  initial begin
    {arst_n, opStrobe, opClass, operandA, result, ctl, bitSelect} = '0;
    operandB = 8'h00;
    {condSel, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      runOp(rows[i]);
      check("flags", statusFlags & rows[i].m, rows[i].e);
    end
    bus(1'b1, `ADDR_STATUS_FLAGS, 32'hffffffff);
    bus(1'b0, `ADDR_STATUS_FLAGS, 0);
    check("main word", rd, 32'hd7);
    bus(1'b1, `ADDR_ALT_STATUS_FLAGS, 32'h12);
    bus(1'b1, `ADDR_STATUS_FLAGS, 32'h85);
    condSweep(8'ha9);
    runOp({`OP_EXCHANGE, 42'h0});
    check("main swap", statusFlags, 8'h12);
    check("alt swap", alternateFlags, 8'h85);
    condSweep(8'h55);
    bus(1'b1, 8'h0c, 32'hff);
    bus(1'b0, 8'h0c, 0);
    check("unmapped", rd, 32'h0);
    check("unmapped write", statusFlags, 8'h12);
    bus(1'b0, `ADDR_ALT_STATUS_FLAGS, 0);
    check("alt word", rd, 32'h85);
    condSel <= 3'h6;
    bus(1'b0, `ADDR_CONDITION, 0);
    check("cond word", rd, 32'h1);
    arst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    check("reset", {statusFlags, alternateFlags}, 16'h0);
    check("reset rdata", hrdata, 32'h0);
    arst_n <= 1'b1;
    runOp({`OP_SET_CARRY, 42'h0});
    check("after reset", statusFlags, 8'h01);
    close_out();
  end
endmodule
`default_nettype wire
